// file: bench/pcqs_station.sv
// Management station model that runs frames on the serial management port.
// Assumes the bench resolves the shared data wire and feeds it back on mdio_i.
`timescale 1ns/1ps
module pcqs_station #(
  parameter int HALF = 8
) (
  // Clock
  input  wire logic clk_i,
  // Management wire
  input  wire logic mdio_i,
  output logic      mdc_o,
  output logic      mdio_o,
  output logic      mdio_oe_n_o
);
  logic ta_seen;

  initial begin
    mdc_o       = 1'b0;
    mdio_o      = 1'b1;
    mdio_oe_n_o = 1'b1;
    ta_seen     = 1'b1;
  end

  // ----------------------------------------------------------------
  // One management clock period, sampled just before the rise
  // ----------------------------------------------------------------
  task automatic bit_cyc(input logic b, input logic drv, output logic s);
    @(negedge clk_i);
    mdc_o       = 1'b0;
    mdio_o      = b;
    mdio_oe_n_o = ~drv;
    repeat (HALF) @(negedge clk_i);
    s     = mdio_i;
    mdc_o = 1'b1;
    repeat (HALF-1) @(negedge clk_i);
  endtask

  // ----------------------------------------------------------------
  // Whole frame; released bus reads back through the pull-up
  // ----------------------------------------------------------------
  task automatic frame(input logic [4:0] addr, input logic rd, input logic [4:0] rg,
                       input logic [15:0] wd, output logic [15:0] q);
    logic [13:0] cmd;
    logic        s;
    cmd = {2'h1, (rd ? 2'h2 : 2'h1), addr, rg};
    for (int i = 0; i < 32; i++) bit_cyc(1'b1, 1'b1, s);
    for (int i = 13; i >= 0; i--) bit_cyc(cmd[i], 1'b1, s);
    bit_cyc(1'b1, !rd, s);
    bit_cyc(1'b0, !rd, s);
    ta_seen = s;
    for (int i = 15; i >= 0; i--) begin
      bit_cyc(wd[i], !rd, s);
      q[i] = s;
    end
    @(negedge clk_i);
    mdc_o       = 1'b0;
    mdio_oe_n_o = 1'b1;
    repeat (2*HALF) @(negedge clk_i);
  endtask
endmodule // pcqs_station

// file: bench/port_config_quick_status_tb.sv
// Self-checking bench for the port config / quick status registers.
// Assumes the station model for frames and a pull-up on the data wire.
`timescale 1ns/1ps
`include "pcqs_cfg.svh"
module port_config_quick_status_tb
  import pcqs_pkg::*;
;
  localparam logic [4:0] PHY = 5'h01;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        mdc, st_mdio, st_oe_n, dut_mdio, dut_oe_n, mdio_w;
  logic        med_pin = 1'b1;
  logic        pre_pin = 1'b0;
  logic [3:0]  lv = 4'h0;
  logic [3:0]  ev = 4'h0;
  logic        fib, pre, rdy, pre2;
  logic [15:0] q;
  int          fails = 0;
  int          tests_run = 0;

  always #12.5 clk = ~clk;
  assign mdio_w = !dut_oe_n ? dut_mdio : (!st_oe_n ? st_mdio : 1'b1);

  pcqs_station #(.HALF(8)) st (.clk_i(clk), .mdio_i(mdio_w), .mdc_o(mdc), .mdio_o(st_mdio), .mdio_oe_n_o(st_oe_n));

  pcqs_port_regs uut (
    .clk_i(clk), .rst_n_i(rst_n), .mdc_i(mdc), .mdio_i(mdio_w), .mdio_o(dut_mdio), .mdio_oe_n_o(dut_oe_n),
    .phy_addr_i(PHY), .media_select_pin_i(med_pin), .preamble_select_pin_i(pre_pin),
    .speed_100_i(lv[3]), .tx_active_i(ev[3]), .rx_packet_i(ev[2]), .collision_i(ev[1]), .jabber_i(ev[0]),
    .link_up_i(lv[2]), .full_duplex_i(lv[1]), .autoneg_en_i(lv[0]),
    .fiber_mode_o(fib), .preamble_en_o(pre), .ready_o(rdy));

  pcqs_port_regs #(.HAS_PREAMBLE_PIN(1'b0)) uut_nopin (
    .clk_i(clk), .rst_n_i(rst_n), .mdc_i(mdc), .mdio_i(mdio_w), .mdio_o(), .mdio_oe_n_o(),
    .phy_addr_i(5'h1F), .media_select_pin_i(med_pin), .preamble_select_pin_i(pre_pin),
    .speed_100_i(lv[3]), .tx_active_i(ev[3]), .rx_packet_i(ev[2]), .collision_i(ev[1]), .jabber_i(ev[0]),
    .link_up_i(lv[2]), .full_duplex_i(lv[1]), .autoneg_en_i(lv[0]),
    .fiber_mode_o(), .preamble_en_o(pre2), .ready_o());

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %0t got %h want %h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic do_reset(input logic m, input logic p);
    @(negedge clk);
    rst_n   = 1'b0;
    med_pin = m;
    pre_pin = p;
    repeat (10) @(negedge clk);
    rst_n = 1'b1;
    repeat (12) @(negedge clk);
    check(rdy, 16'h0001);
  endtask

  task automatic rd_chk(input logic [4:0] rg, input logic [15:0] exp);
    st.frame(PHY, 1'b1, rg, 16'h0000, q);
    check(q, exp);
  endtask

  task automatic wr(input logic [4:0] rg, input logic [15:0] d);
    st.frame(PHY, 1'b0, rg, d, q);
  endtask

  function automatic logic [15:0] st_exp(input logic [3:0] l, input logic [2:0] e);
    return {1'b0, l[3], e, l[2:0], 8'h00};
  endfunction

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    do_reset(1'b1, 1'b0);
    check(fib, 16'h0001);
    check(pre, 16'h0000);
    rd_chk(`PCQS_REG_PORT_CFG, 16'h0001);
    rd_chk(`PCQS_REG_QUICK_STAT, 16'h0000);
    do_reset(1'b0, 1'b1);
    check(fib, 16'h0000);
    check(pre, 16'h0001);
    check(pre2, 16'h0000);
    rd_chk(`PCQS_REG_PORT_CFG, 16'h0020);
    wr(`PCQS_REG_PORT_CFG, 16'hFFFD);
    check(fib, 16'h0001);
    rd_chk(`PCQS_REG_PORT_CFG, 16'h0021);
    check(st.ta_seen, 16'h0000);
    wr(`PCQS_REG_PORT_CFG, 16'h0000);
    check(fib, 16'h0000);
    st.frame(5'h02, 1'b0, `PCQS_REG_PORT_CFG, 16'h0001, q);
    check(fib, 16'h0000);
    st.frame(5'h02, 1'b1, `PCQS_REG_QUICK_STAT, 16'h0000, q);
    check(q, 16'hFFFF);
    rd_chk(5'h12, 16'h0000);
    for (int i = 0; i < 16; i++) begin
      lv = i[3:0];
      rd_chk(`PCQS_REG_QUICK_STAT, st_exp(i[3:0], 3'h0));
    end
    lv = 4'h0;
    for (int j = 0; j < 4; j++) begin
      @(negedge clk);
      ev = 4'h8 >> j;
      @(negedge clk);
      ev = 4'h0;
      rd_chk(`PCQS_REG_QUICK_STAT, (j < 2) ? (16'h2000 >> j) : 16'h0800);
      rd_chk(`PCQS_REG_QUICK_STAT, 16'h0000);
    end
    ev = 4'h4;
    rd_chk(`PCQS_REG_QUICK_STAT, 16'h1000);
    ev = 4'h0;
    rd_chk(`PCQS_REG_QUICK_STAT, 16'h1000);
    rd_chk(`PCQS_REG_QUICK_STAT, 16'h0000);
    lv = 4'hF;
    do_reset(1'b0, 1'b0);
    rd_chk(`PCQS_REG_QUICK_STAT, st_exp(4'hF, 3'h0));
    tally_and_finish();
  end

  // ----------------------------------------------------------------
  // Watchdog
  // ----------------------------------------------------------------
  initial begin
    #2000000;
    fails++;
    tally_and_finish();
  end
endmodule // port_config_quick_status_tb

// file: src/pcqs_cfg.svh
// Offsets, bit positions, reset values and timing counts of the port config / quick status slice.
// Assumes inclusion by the register module and the bench only.
`ifndef PCQS_CFG_SVH
`define PCQS_CFG_SVH

// ----------------------------------------------------------------
// Register offsets (management register numbers)
// ----------------------------------------------------------------
`define PCQS_REG_PORT_CFG     5'h10
`define PCQS_REG_QUICK_STAT   5'h11

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define PCQS_CFG_FIBER_BIT    0
`define PCQS_CFG_RSVD_BIT     1
`define PCQS_CFG_PREAMBLE_BIT 5
`define PCQS_ST_RSVD_BIT      15
`define PCQS_ST_SPEED_BIT     14
`define PCQS_ST_TX_BIT        13
`define PCQS_ST_RX_BIT        12
`define PCQS_ST_COL_BIT       11
`define PCQS_ST_LINK_BIT      10
`define PCQS_ST_DUPLEX_BIT    9
`define PCQS_ST_AN_BIT        8

// ----------------------------------------------------------------
// Reset values and frame codes
// ----------------------------------------------------------------
`define PCQS_RST_WORD         16'h0000
`define PCQS_OP_READ          2'h2
`define PCQS_OP_WRITE         2'h1

// ----------------------------------------------------------------
// Timing counts (clock cycles and management clock edges)
// ----------------------------------------------------------------
`define PCQS_BOOT_CYC         3'h4
`define PCQS_PREAMBLE_LEN     6'h20
`define PCQS_CMD_LAST         5'h0B
`define PCQS_DATA_LAST        5'h0F

`endif

// file: src/pcqs_pin_sync.sv
// Three-stage synchroniser for pins from outside the clock domain.
// Assumes a single system clock; a change is accepted once stages two and three agree.
`timescale 1ns/1ps
module pcqs_pin_sync #(
  parameter int W = 4
) (
  // Clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  // Pins and filtered levels
  input  wire logic [W-1:0] pin_i,
  output logic      [W-1:0] level_o
);

  // ----------------------------------------------------------------
  // Per-bit stages
  // ----------------------------------------------------------------
  for (genvar g = 0; g < W; g++) begin : g_bit
    logic s1_q;
    logic s2_q;
    logic s3_q;
    logic lvl_q;
    logic lvl_d;
    always_comb begin
      lvl_d = (s2_q == s3_q) ? s3_q : lvl_q;
    end
    // Stages run through reset so strap levels are settled at release
    always_ff @(posedge clk_i) begin
      s1_q <= pin_i[g];
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
    always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
        lvl_q <= 1'b0;
      end else begin
        lvl_q <= lvl_d;
      end
    end
    assign level_o[g] = lvl_q;
  end

endmodule // pcqs_pin_sync

// file: src/pcqs_pkg.sv
// Types shared by the port config / quick status slice.
// Assumes nothing beyond the constants header.
package pcqs_pkg;

  // ----------------------------------------------------------------
  // Management frame states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    PCQS_PRE   = 3'b000,
    PCQS_START = 3'b001,
    PCQS_CMD   = 3'b010,
    PCQS_TA    = 3'b011,
    PCQS_DATA  = 3'b100
  } pcqs_state_e;

  // ----------------------------------------------------------------
  // Register contents
  // ----------------------------------------------------------------
  typedef struct packed {
    logic preamble_en;
    logic fiber;
  } pcqs_cfg_s;

  typedef struct packed {
    logic tx;
    logic rx;
    logic col;
  } pcqs_lh_s;

  typedef struct packed {
    logic speed_100;
    logic link;
    logic full_duplex;
    logic autoneg;
  } pcqs_live_s;

endpackage

// file: src/pcqs_port_regs.sv
// Port configuration (low bits) and quick status (upper half) registers behind the serial management port.
// Assumes management clock far slower than clk_i; datapath status inputs share clk_i.
// Operation
// [R1] The media select bit picks twisted pair when 0 and fiber when 1.
// [R2] After reset the media select bit takes 0 if its configuration pin is low and 1 otherwise.
// [R3] The preamble enable bit defaults from its configuration pin, or to 0 where the package lacks that pin.
// [R4] Pin-derived defaults are caught by latching the configuration pins at startup or hardware reset.
// [R5] Fields without a default may start with any value and no logic relies on their initial contents.
// [R6] Reserved configuration bit 1 and status bit 15 read as 0 and writes to them are ignored.
// [R7] Status bit 14 reads 0 at 10 Mbps and 1 at 100 Mbps, for copper and fiber alike.
// [R8] Status bit 13 latches high while a packet is transmitted and holds until read.
// [R9] Status bit 12 latches when a packet was received since the last read and clears on read.
// [R10] Status bit 11 latches on a collision and on jabber regardless of duplex, meaningful only with link up.
// [R11] Status bit 10 shows link up as 1 and link down as 0, resetting to 0.
// [R12] Status bit 9 shows full duplex as 1 and half duplex as 0, resetting to 0.
// [R13] Status bit 8 mirrors the auto-negotiation enable control bit.
// [R14] Status contents are refreshed when reset completes so they show the state at that moment.
// [R15] The management station should read the status register once reset has completed.
// [R16] A read clears latching bits only after capturing them, and a same-cycle event stays set.
`timescale 1ns/1ps
`include "pcqs_cfg.svh"
module pcqs_port_regs
  import pcqs_pkg::*;
#(
  parameter bit HAS_PREAMBLE_PIN = 1'b1
) (
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  // Serial management port
  input  wire logic       mdc_i,
  input  wire logic       mdio_i,
  output logic            mdio_o,
  output logic            mdio_oe_n_o,
  input  wire logic [4:0] phy_addr_i,
  // Configuration pins
  input  wire logic       media_select_pin_i,
  input  wire logic       preamble_select_pin_i,
  // Port status from the datapath
  input  wire logic       speed_100_i,
  input  wire logic       tx_active_i,
  input  wire logic       rx_packet_i,
  input  wire logic       collision_i,
  input  wire logic       jabber_i,
  input  wire logic       link_up_i,
  input  wire logic       full_duplex_i,
  input  wire logic       autoneg_en_i,
  // Configuration and ready status to the datapath
  output logic            fiber_mode_o,
  output logic            preamble_en_o,
  output logic            ready_o
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [3:0] pin_s;
  pcqs_pin_sync #(.W(4)) u_sync (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .pin_i   ({preamble_select_pin_i, media_select_pin_i, mdio_i, mdc_i}),
    .level_o (pin_s)
  );

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic [2:0]  boot_q, boot_d;
  pcqs_cfg_s   cfg_q, cfg_d;
  pcqs_lh_s    lh_q, lh_d, lh_ev;
  pcqs_live_s  live_q, live_d;
  logic        boot_load;
  logic        rd_clr;
  logic        cfg_we;
  logic [15:0] wr_data;
  logic [15:0] cfg_word;
  logic [15:0] stat_word;

  assign boot_load = (boot_q == 3'h1);
  assign lh_ev     = '{tx: tx_active_i, rx: rx_packet_i, col: collision_i | jabber_i}; // R8 R9 R10

  always_comb begin
    boot_d = (boot_q != 3'h0) ? boot_q - 3'h1 : boot_q;
    cfg_d  = cfg_q;
    if (boot_load) begin
      cfg_d.fiber       = pin_s[2]; // R2 R4
      cfg_d.preamble_en = HAS_PREAMBLE_PIN ? pin_s[3] : 1'b0; // R3 R4
    end else if (cfg_we) begin
      cfg_d.fiber       = wr_data[`PCQS_CFG_FIBER_BIT]; // R1
      cfg_d.preamble_en = wr_data[`PCQS_CFG_PREAMBLE_BIT];
    end
    lh_d   = (lh_q & ~{3{rd_clr}}) | lh_ev; // R16
    live_d = '{speed_100: speed_100_i, link: link_up_i, full_duplex: full_duplex_i, autoneg: autoneg_en_i}; // R7 R13 R14
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      boot_q <= `PCQS_BOOT_CYC;
      cfg_q  <= '0;
      lh_q   <= '0;
      live_q <= '0; // R11 R12
    end else begin
      boot_q <= boot_d;
      cfg_q  <= cfg_d;
      lh_q   <= lh_d;
      live_q <= live_d;
    end
  end

  always_comb begin
    cfg_word                         = `PCQS_RST_WORD; // R6
    cfg_word[`PCQS_CFG_FIBER_BIT]    = cfg_q.fiber;
    cfg_word[`PCQS_CFG_PREAMBLE_BIT] = cfg_q.preamble_en;
    stat_word                        = `PCQS_RST_WORD; // R6
    stat_word[`PCQS_ST_SPEED_BIT]    = live_q.speed_100; // R7
    stat_word[`PCQS_ST_TX_BIT]       = lh_q.tx; // R8
    stat_word[`PCQS_ST_RX_BIT]       = lh_q.rx; // R9
    stat_word[`PCQS_ST_COL_BIT]      = lh_q.col; // R10
    stat_word[`PCQS_ST_LINK_BIT]     = live_q.link; // R11
    stat_word[`PCQS_ST_DUPLEX_BIT]   = live_q.full_duplex; // R12
    stat_word[`PCQS_ST_AN_BIT]       = live_q.autoneg; // R13
  end

  assign fiber_mode_o  = cfg_q.fiber; // R1
  assign preamble_en_o = cfg_q.preamble_en;
  assign ready_o       = (boot_q == 3'h0);

  // ----------------------------------------------------------------
  // Management frame engine
  // ----------------------------------------------------------------
  pcqs_state_e st_q, st_d;
  logic [5:0]  cnt_q, cnt_d;
  logic [15:0] sh_q, sh_d;
  logic [15:0] out_q, out_d;
  logic        rd_q, rd_d;
  logic        hit_q, hit_d;
  logic [4:0]  reg_q, reg_d;
  logic        drv_q, drv_d;
  logic        bit_q, bit_d;
  logic        mdc_prev_q;
  logic        rise;
  logic        din;
  logic [15:0] sh_nx;

  assign rise    = pin_s[0] & ~mdc_prev_q;
  assign din     = pin_s[1];
  assign sh_nx   = {sh_q[14:0], din};
  assign wr_data = sh_nx;

  always_comb begin
    st_d   = st_q;
    cnt_d  = cnt_q;
    sh_d   = sh_q;
    out_d  = out_q;
    rd_d   = rd_q;
    hit_d  = hit_q;
    reg_d  = reg_q;
    drv_d  = drv_q;
    bit_d  = bit_q;
    rd_clr = 1'b0;
    cfg_we = 1'b0;
    if (rise && ready_o) begin
      case (st_q)
        PCQS_PRE: begin
          if (din) begin
            cnt_d = (cnt_q == `PCQS_PREAMBLE_LEN) ? cnt_q : cnt_q + 6'h01;
          end else begin
            st_d  = (cnt_q == `PCQS_PREAMBLE_LEN) ? PCQS_START : PCQS_PRE;
            cnt_d = 6'h00;
          end
        end
        PCQS_START: begin
          st_d  = din ? PCQS_CMD : PCQS_PRE;
          cnt_d = 6'h00;
        end
        PCQS_CMD: begin
          sh_d  = sh_nx; // R5
          cnt_d = cnt_q + 6'h01;
          if (cnt_q[4:0] == `PCQS_CMD_LAST) begin
            st_d  = PCQS_TA;
            cnt_d = 6'h00;
            rd_d  = (sh_nx[11:10] == `PCQS_OP_READ);
            hit_d = (sh_nx[9:5] == phy_addr_i) &&
                    ((sh_nx[11:10] == `PCQS_OP_READ) || (sh_nx[11:10] == `PCQS_OP_WRITE));
            reg_d = sh_nx[4:0];
            if (sh_nx[4:0] == `PCQS_REG_PORT_CFG) begin
              out_d = cfg_word;
            end else if (sh_nx[4:0] == `PCQS_REG_QUICK_STAT) begin
              out_d = stat_word;
              rd_clr = (sh_nx[9:5] == phy_addr_i) && (sh_nx[11:10] == `PCQS_OP_READ); // R16
            end else begin
              out_d = `PCQS_RST_WORD;
            end
          end
        end
        PCQS_TA: begin
          cnt_d = cnt_q + 6'h01;
          if (cnt_q == 6'h00) begin
            drv_d = rd_q && hit_q;
            bit_d = 1'b0;
          end else begin
            st_d  = PCQS_DATA;
            cnt_d = 6'h00;
            bit_d = out_q[15];
            out_d = {out_q[14:0], 1'b0};
          end
        end
        PCQS_DATA: begin
          cnt_d = cnt_q + 6'h01;
          sh_d  = sh_nx;
          bit_d = out_q[15];
          out_d = {out_q[14:0], 1'b0};
          if (cnt_q[4:0] == `PCQS_DATA_LAST) begin
            st_d   = PCQS_PRE;
            cnt_d  = 6'h00;
            drv_d  = 1'b0;
            bit_d  = 1'b0;
            cfg_we = !rd_q && hit_q && (reg_q == `PCQS_REG_PORT_CFG); // R6
          end
        end
        default: begin
          st_d  = PCQS_PRE;
          cnt_d = 6'h00;
          drv_d = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      st_q       <= PCQS_PRE;
      cnt_q      <= 6'h00;
      rd_q       <= 1'b0;
      hit_q      <= 1'b0;
      reg_q      <= 5'h00;
      drv_q      <= 1'b0;
      bit_q      <= 1'b0;
      mdc_prev_q <= 1'b0;
    end else begin
      st_q       <= st_d;
      cnt_q      <= cnt_d;
      rd_q       <= rd_d;
      hit_q      <= hit_d;
      reg_q      <= reg_d;
      drv_q      <= drv_d;
      bit_q      <= bit_d;
      mdc_prev_q <= pin_s[0];
    end
  end

  always_ff @(posedge clk_i) begin
    sh_q  <= sh_d;
    out_q <= out_d;
  end

  assign mdio_o      = bit_q;
  assign mdio_oe_n_o = ~drv_q;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  a_boot_media: assert property (boot_load |=> fiber_mode_o == $past(pin_s[2])) // R2
    else $error("media select default not taken from pin");
  a_boot_preamble: assert property (boot_load |=> preamble_en_o == (HAS_PREAMBLE_PIN & $past(pin_s[3]))) // R3
    else $error("preamble enable default wrong");
  a_media_hold: assert property (ready_o && !cfg_we |=> $stable(fiber_mode_o)) // R1
    else $error("media select changed without a write");
  a_tx_latch: assert property (tx_active_i ##1 !rd_clr |=> lh_q.tx) // R8
    else $error("transmit status did not hold");
  a_rx_set_wins: assert property (rx_packet_i && rd_clr |=> lh_q.rx) // R9
    else $error("receive event lost on clearing read");
  a_col_jabber: assert property (jabber_i && !collision_i |=> lh_q.col) // R10
    else $error("jabber did not set collision status");
  a_link_follow: assert property (link_up_i ##1 link_up_i |=> stat_word[`PCQS_ST_LINK_BIT]) // R11
    else $error("link status did not follow");
  a_clear_after_cap: assert property (rd_clr && !tx_active_i |=> !lh_q.tx && out_q[`PCQS_ST_TX_BIT] == $past(lh_q.tx)) // R16
    else $error("transmit status not captured then cleared");
  a_rsvd_first: assert property (st_q == PCQS_TA && cnt_q == 6'h01 && rise && hit_q && rd_q
                                 && reg_q == `PCQS_REG_QUICK_STAT |=> !mdio_o && !mdio_oe_n_o) // R6
    else $error("reserved status bit not driven low");
  a_oe_release: assert property (st_q == PCQS_DATA && cnt_q == 6'h0F && rise |=> mdio_oe_n_o)
    else $error("data line not released after frame");
  a_speed_follow: assert property (ready_o |=> stat_word[`PCQS_ST_SPEED_BIT] == $past(speed_100_i)) // R7
    else $error("speed status did not follow");
  a_duplex_follow: assert property (ready_o |=> stat_word[`PCQS_ST_DUPLEX_BIT] == $past(full_duplex_i)) // R12
    else $error("duplex status did not follow");
  a_an_mirror: assert property (ready_o |=> stat_word[`PCQS_ST_AN_BIT] == $past(autoneg_en_i)) // R13
    else $error("auto-negotiation status did not mirror control");
  a_rx_clear: assert property (rd_clr && !rx_packet_i |=> !lh_q.rx) // R9
    else $error("receive status not cleared by read");
  a_col_clear: assert property (rd_clr && !collision_i && !jabber_i |=> !lh_q.col) // R10
    else $error("collision status not cleared by read");
  a_cfg_write: assert property (cfg_we |=> fiber_mode_o == $past(wr_data[`PCQS_CFG_FIBER_BIT])) // R1
    else $error("media select write not applied");
  a_wr_quiet: assert property (st_q == PCQS_DATA && !rd_q |-> mdio_oe_n_o)
    else $error("data line driven during a write frame");

endmodule // pcqs_port_regs
